// ### csc_chan_sel.sv
// Subscribe decode: combinational trigger, high while the chosen channel event is high and the subscription is on
`timescale 1ns/1ps
`include "csc_defines.svh"
module csc_chan_sel
  import csc_pkg::*;
(
  // Channel events
  input  wire logic [`CSC_NUM_CH-1:0] chan_evt,
  // Subscription
  input  wire logic [`CSC_CH_W-1:0]   chan,
  input  wire logic                   en,
  // Result
  output logic                        fire
);

  assign fire = en && chan_evt[chan]; // RULE11 RULE12

endmodule // csc_chan_sel

// ### csc_clock_ctrl.sv
// Clock source control: task, subscribe, publish, event and status registers
// Overview of operation
// RULE1 - Start task write starts fast clock
// RULE2 - Stop task write stops fast clock
// RULE3 - Start task write starts slow clock
// RULE4 - Stop task write stops slow clock
// RULE5 - Slow start uses currently selected source
// RULE6 - Slow start copies selection to latched register
// RULE7 - Slow run flag shows start triggered
// RULE8 - Slow status gives source and running
// RULE9 - Fast run flag shows start triggered
// RULE10 - Fast status gives crystal request and running
// RULE11 - Subscribe channel index picks one of sixteen
// RULE12 - Subscribe enable bit gates task trigger
// RULE13 - Interrupt enable registers shared with power block
// RULE14 - Fast started flag set once running
// RULE15 - Fast started published on chosen channel
// RULE16 - Subscribed event acts like task write
// RULE17 - Task registers write-only, reads zero
`timescale 1ns/1ps
`include "csc_defines.svh"
module csc_clock_ctrl
  import csc_pkg::*;
(
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    resetn,
  // Register port
  input  wire logic [`CSC_ADDR_W-1:0]  addr,
  input  wire logic [31:0]             wdata,
  input  wire logic                    wr,
  input  wire logic                    rd,
  output logic      [31:0]             rdata,
  // Event interconnect
  input  wire logic [`CSC_NUM_CH-1:0]  chan_evt,
  output logic      [`CSC_NUM_CH-1:0]  chan_pub,
  // Shared interrupt enable held in the power block
  input  wire logic [`CSC_IRQ_W-1:0]   irq_en_shared,
  output logic      [`CSC_IRQ_W-1:0]   irq_en_set,
  output logic      [`CSC_IRQ_W-1:0]   irq_en_clr,
  // Oscillator controls
  output logic                         fast_osc_on,
  output logic                         slow_osc_on,
  output logic      [`CSC_SRC_W-1:0]   slow_osc_src
);

  typedef struct packed {
    csc_cfg_s [3:0]          sub;
    csc_cfg_s [1:0]          pub;
    logic                    fast_started_flag;
    logic                    slow_started_flag;
    logic                    fast_run_flag;
    logic                    slow_run_flag;
    logic [`CSC_SRC_W-1:0]   slow_source_sel;
    logic [`CSC_SRC_W-1:0]   slow_source_latched;
    logic [31:0]             rdata;
    logic [`CSC_NUM_CH-1:0]  pub_out;
    logic [`CSC_IRQ_W-1:0]   ie_set;
    logic [`CSC_IRQ_W-1:0]   ie_clr;
    logic                    fast_on;
    logic                    slow_on;
  } csc_state_s;

  csc_state_s st_r, st_nxt;

  // Task index: 0 fast start, 1 fast stop, 2 slow start, 3 slow stop
  logic [3:0] sub_fire;
  logic [3:0] task_go;
  logic       fast_running;
  logic       slow_running;
  logic       fast_started_p;
  logic       slow_started_p;
  logic       wr_one;

  assign wr_one = wr && wdata[0];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sub
      csc_chan_sel u_sel (
        .chan_evt (chan_evt),
        .chan     (st_r.sub[gi].chan),
        .en       (st_r.sub[gi].en),
        .fire     (sub_fire[gi])
      );
    end
  endgenerate

  // Writing zero to a task has no effect; a channel event is equivalent to writing one
  assign task_go[0] = sub_fire[0] || (wr_one && addr == `CSC_OFF_HF_START); // RULE1 RULE16 RULE17
  assign task_go[1] = sub_fire[1] || (wr_one && addr == `CSC_OFF_HF_STOP);  // RULE2 RULE16
  assign task_go[2] = sub_fire[2] || (wr_one && addr == `CSC_OFF_LF_START); // RULE3 RULE16
  assign task_go[3] = sub_fire[3] || (wr_one && addr == `CSC_OFF_LF_STOP);  // RULE4 RULE16

  csc_osc_seq #(
    .SETTLE (8'(`CSC_HF_SETTLE_CYC))
  ) u_fast (
    .clock         (clock),
    .resetn        (resetn),
    .start         (task_go[0]),
    .stop          (task_go[1]),
    .running       (fast_running),
    .started_pulse (fast_started_p)
  );

  csc_osc_seq #(
    .SETTLE (8'(`CSC_LF_SETTLE_CYC))
  ) u_slow (
    .clock         (clock),
    .resetn        (resetn),
    .start         (task_go[2]),
    .stop          (task_go[3]),
    .running       (slow_running),
    .started_pulse (slow_started_p)
  );

  function automatic logic [31:0] cfg_word(input csc_cfg_s c);
    logic [31:0] w;
    w = `CSC_RESET_WORD;
    w[`CSC_CH_W-1:0]   = c.chan;
    w[`CSC_CFG_EN_BIT] = c.en;
    return w;
  endfunction

  function automatic csc_cfg_s cfg_from(input logic [31:0] w);
    csc_cfg_s c;
    c.chan = w[`CSC_CH_W-1:0];
    c.en   = w[`CSC_CFG_EN_BIT];
    return c;
  endfunction

  always_comb begin
    st_nxt        = st_r;
    st_nxt.rdata  = `CSC_RESET_WORD;
    st_nxt.ie_set = '0;
    st_nxt.ie_clr = '0;

    // Register writes
    if (wr) begin
      unique case (addr)
        `CSC_OFF_HF_START_SUB: st_nxt.sub[0] = cfg_from(wdata); // RULE11 RULE12
        `CSC_OFF_HF_STOP_SUB:  st_nxt.sub[1] = cfg_from(wdata);
        `CSC_OFF_LF_START_SUB: st_nxt.sub[2] = cfg_from(wdata);
        `CSC_OFF_LF_STOP_SUB:  st_nxt.sub[3] = cfg_from(wdata);
        `CSC_OFF_HF_PUB:       st_nxt.pub[0] = cfg_from(wdata); // RULE15
        `CSC_OFF_LF_PUB:       st_nxt.pub[1] = cfg_from(wdata);
        `CSC_OFF_HF_STARTED:   st_nxt.fast_started_flag = wdata[0];
        `CSC_OFF_LF_STARTED:   st_nxt.slow_started_flag = wdata[0];
        `CSC_OFF_IRQ_SET:      st_nxt.ie_set = wdata[`CSC_IRQ_W-1:0]; // RULE13
        `CSC_OFF_IRQ_CLR:      st_nxt.ie_clr = wdata[`CSC_IRQ_W-1:0]; // RULE13
        `CSC_OFF_IRQ_EN: begin
          st_nxt.ie_set = wdata[`CSC_IRQ_W-1:0];  // RULE13
          st_nxt.ie_clr = ~wdata[`CSC_IRQ_W-1:0];
        end
        `CSC_OFF_LF_SEL:       st_nxt.slow_source_sel = wdata[`CSC_SRC_W-1:0];
        default: ;
      endcase
    end

    // Hardware sets win over a software clear in the same cycle
    if (fast_started_p) begin
      st_nxt.fast_started_flag = 1'b1; // RULE14
    end
    if (slow_started_p) begin
      st_nxt.slow_started_flag = 1'b1;
    end

    // Run flags follow the start task and drop on stop
    if (task_go[0]) begin
      st_nxt.fast_run_flag = 1'b1; // RULE9
    end else if (task_go[1]) begin
      st_nxt.fast_run_flag = 1'b0;
    end
    if (task_go[2]) begin
      st_nxt.slow_run_flag       = 1'b1;                   // RULE7
      st_nxt.slow_source_latched = st_nxt.slow_source_sel; // RULE5 RULE6
    end else if (task_go[3]) begin
      st_nxt.slow_run_flag = 1'b0;
    end

    // Publish: one-cycle pulse on the selected channel
    st_nxt.pub_out = '0;
    if (fast_started_p && st_r.pub[0].en) begin
      st_nxt.pub_out[st_r.pub[0].chan] = 1'b1; // RULE15
    end
    if (slow_started_p && st_r.pub[1].en) begin
      st_nxt.pub_out[st_r.pub[1].chan] = 1'b1;
    end

    st_nxt.fast_on = fast_running; // RULE1 RULE2
    st_nxt.slow_on = slow_running; // RULE3 RULE4

    // Reads; task offsets and unmapped addresses return zero
    if (rd) begin
      unique case (addr)
        `CSC_OFF_HF_START_SUB: st_nxt.rdata = cfg_word(st_r.sub[0]);
        `CSC_OFF_HF_STOP_SUB:  st_nxt.rdata = cfg_word(st_r.sub[1]);
        `CSC_OFF_LF_START_SUB: st_nxt.rdata = cfg_word(st_r.sub[2]);
        `CSC_OFF_LF_STOP_SUB:  st_nxt.rdata = cfg_word(st_r.sub[3]);
        `CSC_OFF_HF_PUB:       st_nxt.rdata = cfg_word(st_r.pub[0]);
        `CSC_OFF_LF_PUB:       st_nxt.rdata = cfg_word(st_r.pub[1]);
        `CSC_OFF_HF_STARTED:   st_nxt.rdata[0] = st_r.fast_started_flag;
        `CSC_OFF_LF_STARTED:   st_nxt.rdata[0] = st_r.slow_started_flag;
        `CSC_OFF_IRQ_EN,
        `CSC_OFF_IRQ_SET,
        `CSC_OFF_IRQ_CLR:      st_nxt.rdata[`CSC_IRQ_W-1:0] = irq_en_shared; // RULE13
        `CSC_OFF_HF_RUN:       st_nxt.rdata[0] = st_r.fast_run_flag; // RULE9
        `CSC_OFF_HF_STAT: begin
          st_nxt.rdata[0]              = st_r.fast_run_flag; // RULE10
          st_nxt.rdata[`CSC_STATE_BIT] = st_r.fast_on;
        end
        `CSC_OFF_LF_RUN:       st_nxt.rdata[0] = st_r.slow_run_flag; // RULE7
        `CSC_OFF_LF_STAT: begin
          st_nxt.rdata[`CSC_SRC_W-1:0] = st_r.slow_source_latched; // RULE8
          st_nxt.rdata[`CSC_STATE_BIT] = st_r.slow_on;
        end
        `CSC_OFF_LF_COPY:      st_nxt.rdata[`CSC_SRC_W-1:0] = st_r.slow_source_latched; // RULE6
        `CSC_OFF_LF_SEL:       st_nxt.rdata[`CSC_SRC_W-1:0] = st_r.slow_source_sel;
        default:               st_nxt.rdata = `CSC_RESET_WORD; // RULE17
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata        = st_r.rdata;
  assign chan_pub     = st_r.pub_out;
  assign irq_en_set   = st_r.ie_set;
  assign irq_en_clr   = st_r.ie_clr;
  assign fast_osc_on  = st_r.fast_on;
  assign slow_osc_on  = st_r.slow_on;
  assign slow_osc_src = st_r.slow_source_latched; // RULE5

endmodule // csc_clock_ctrl

// ### csc_clock_ctrl_sva.sv
// Port assertions for clock source control
`timescale 1ns/1ps
`include "csc_defines.svh"
module csc_sva
  import csc_pkg::*;
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        resetn,
  // Register port
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  // Interconnect and interrupt enables
  input wire logic [15:0] chan_evt,
  input wire logic [15:0] chan_pub,
  input wire logic [1:0]  irq_en_shared,
  input wire logic [1:0]  irq_en_set,
  input wire logic [1:0]  irq_en_clr,
  // Oscillators
  input wire logic        fast_osc_on,
  input wire logic        slow_osc_on,
  input wire logic [1:0]  slow_osc_src
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  logic [31:0] sub_r;
  logic [31:0] pub_r;
  logic [1:0]  sel_r;
  wire logic [1:0] wlo = wdata[1:0];
  wire logic fast_go = wr && addr == 12'h000 && wdata[0];
  wire logic slow_go = wr && addr == 12'h008 && wdata[0];
  // Shadow of the config words so checks need no register reads
  always_ff @(posedge clock) begin
    if (!resetn) begin
      sub_r <= 32'h0000_0000;
      pub_r <= 32'h0000_0000;
      sel_r <= 2'h0;
    end else if (wr) begin
      if (addr == 12'h080) sub_r <= wdata;
      if (addr == 12'h180) pub_r <= wdata;
      if (addr == 12'h518) sel_r <= wlo;
    end
  end
  property p_fast_on;
    fast_go && !fast_osc_on |-> ##[20:23] fast_osc_on;
  endproperty
  property p_fast_off;
    wr && addr == 12'h004 && wdata[0] |-> ##[1:3] !fast_osc_on;
  endproperty
  property p_slow_on;
    slow_go && !slow_osc_on |-> ##[10:13] slow_osc_on;
  endproperty
  property p_slow_off;
    wr && addr == 12'h00c && wdata[0] |-> ##[1:3] !slow_osc_on;
  endproperty
  property p_src;
    slow_go && !slow_osc_on |=> ##[0:2] slow_osc_src == sel_r;
  endproperty
  property p_sub;
    chan_evt[sub_r[3:0]] && sub_r[31] && !fast_osc_on && !wr |-> ##[20:23] fast_osc_on;
  endproperty
  property p_pub;
    $rose(fast_osc_on) && pub_r[31] |-> chan_pub == 16'h0001 << pub_r[3:0];
  endproperty
  property p_irq;
    wr && addr == 12'h304 |=> irq_en_set == $past(wlo);
  endproperty
  property p_task_rd;
    rd && addr <= 12'h00c |=> rdata == 32'h0000_0000;
  endproperty
  property p_rd_idle;
    !$past(rd) |-> rdata == 32'h0000_0000;
  endproperty
  a_fast_on: assert property (p_fast_on) else $error("fast clock late");
  a_fast_off: assert property (p_fast_off) else $error("fast clock not stopped");
  a_slow_on: assert property (p_slow_on) else $error("slow clock late");
  a_slow_off: assert property (p_slow_off) else $error("slow clock not stopped");
  a_src: assert property (p_src) else $error("slow source wrong");
  a_sub: assert property (p_sub) else $error("subscribed start missing");
  a_pub: assert property (p_pub) else $error("publish pulse wrong");
  a_irq: assert property (p_irq) else $error("irq enable set wrong");
  a_task_rd: assert property (p_task_rd) else $error("task read not zero");
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  c_fast: cover property ($rose(fast_osc_on));
  c_slow: cover property ($rose(slow_osc_on));
  c_pub: cover property (chan_pub != 16'h0000);
endmodule // csc_sva

bind csc_clock_ctrl csc_sva u_csc_sva (.clock, .resetn, .addr, .wdata, .wr, .rd, .rdata, .chan_evt, .chan_pub,
  .irq_en_shared, .irq_en_set, .irq_en_clr, .fast_osc_on, .slow_osc_on, .slow_osc_src);

// ### csc_defines.svh
// Register offsets, field positions, reset values and timing counts for clock source control
`ifndef CSC_DEFINES_SVH
`define CSC_DEFINES_SVH

`define CSC_ADDR_W            12
`define CSC_OFF_HF_START      12'h000
`define CSC_OFF_HF_STOP       12'h004
`define CSC_OFF_LF_START      12'h008
`define CSC_OFF_LF_STOP       12'h00c
`define CSC_OFF_HF_START_SUB  12'h080
`define CSC_OFF_HF_STOP_SUB   12'h084
`define CSC_OFF_LF_START_SUB  12'h088
`define CSC_OFF_LF_STOP_SUB   12'h08c
`define CSC_OFF_HF_STARTED    12'h100
`define CSC_OFF_LF_STARTED    12'h104
`define CSC_OFF_HF_PUB        12'h180
`define CSC_OFF_LF_PUB        12'h184
`define CSC_OFF_IRQ_EN        12'h300
`define CSC_OFF_IRQ_SET       12'h304
`define CSC_OFF_IRQ_CLR       12'h308
`define CSC_OFF_HF_RUN        12'h408
`define CSC_OFF_HF_STAT       12'h40c
`define CSC_OFF_LF_RUN        12'h414
`define CSC_OFF_LF_STAT       12'h418
`define CSC_OFF_LF_COPY       12'h41c
`define CSC_OFF_LF_SEL        12'h518

`define CSC_CH_W              4
`define CSC_NUM_CH            16
`define CSC_CFG_EN_BIT        31
`define CSC_STATE_BIT         16
`define CSC_SRC_W             2
`define CSC_SRC_RESET         2'h0
`define CSC_IRQ_W             2
`define CSC_RESET_WORD        32'h0000_0000

// Oscillator settle times in ns; cycles at 20 MHz round up
`define CSC_CLK_NS            50
`define CSC_HF_SETTLE_NS      1000
`define CSC_LF_SETTLE_NS      500
`define CSC_HF_SETTLE_CYC     ((`CSC_HF_SETTLE_NS + `CSC_CLK_NS - 1) / `CSC_CLK_NS)
`define CSC_LF_SETTLE_CYC     ((`CSC_LF_SETTLE_NS + `CSC_CLK_NS - 1) / `CSC_CLK_NS)
`define CSC_CNT_W             8

`endif

// ### csc_osc_seq.sv
// Start/stop sequencer for one clock source with a settle counter
`timescale 1ns/1ps
`include "csc_defines.svh"
module csc_osc_seq
  import csc_pkg::*;
#(
  parameter logic [`CSC_CNT_W-1:0] SETTLE = 8'h01
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  // Requests
  input  wire logic start,
  input  wire logic stop,
  // Status
  output logic      running,
  output logic      started_pulse
);

  typedef struct packed {
    csc_osc_e               st;
    logic [`CSC_CNT_W-1:0]  cnt;
    logic                   run;
    logic                   pulse;
  } csc_seq_s;

  csc_seq_s s_r, s_nxt;

  always_comb begin
    s_nxt       = s_r;
    s_nxt.pulse = 1'b0;
    unique case (s_r.st)
      CSC_OSC_OFF: begin
        if (start && !stop) begin
          s_nxt.st  = CSC_OSC_STARTING;
          s_nxt.cnt = SETTLE;
        end
      end
      CSC_OSC_STARTING: begin
        if (stop) begin
          s_nxt.st = CSC_OSC_OFF;
        end else if (s_r.cnt <= 8'h01) begin
          s_nxt.st    = CSC_OSC_RUNNING;
          s_nxt.run   = 1'b1;
          s_nxt.pulse = 1'b1;
        end else begin
          s_nxt.cnt = s_r.cnt - 8'h01;
        end
      end
      CSC_OSC_RUNNING: begin
        if (stop) begin
          s_nxt.st  = CSC_OSC_OFF;
          s_nxt.run = 1'b0;
        end
      end
      default: begin
        s_nxt.st  = CSC_OSC_OFF;
        s_nxt.run = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_r <= '{st: CSC_OSC_OFF, cnt: '0, run: 1'b0, pulse: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign running       = s_r.run;
  assign started_pulse = s_r.pulse;

endmodule // csc_osc_seq

// ### csc_pkg.sv
// Types for clock source control
package csc_pkg;
  `include "csc_defines.svh"

  typedef enum logic [1:0] {
    CSC_OSC_OFF,
    CSC_OSC_STARTING,
    CSC_OSC_RUNNING
  } csc_osc_e;

  typedef struct packed {
    logic [`CSC_CH_W-1:0] chan;
    logic                 en;
  } csc_cfg_s;
endpackage

// ### tb_top.sv
// Register-level testbench for clock source control
`timescale 1ns/1ps
`include "csc_defines.svh"
module tb_top
  import csc_pkg::*;
;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] chan_evt = 16'h0000;
  logic [1:0]  irq_en_shared = 2'h2;
  logic [31:0] rdata;
  logic [15:0] chan_pub;
  logic [15:0] pub_seen = 16'h0000;
  logic [1:0]  irq_en_set;
  logic [1:0]  irq_en_clr;
  logic        fast_osc_on;
  logic        slow_osc_on;
  logic [1:0]  slow_osc_src;
  int          miscompares = 0;
  int          check_count = 0;

  always #25 clock = ~clock;
  always @(posedge clock) if (chan_pub != 16'h0000) pub_seen <= chan_pub;

  csc_clock_ctrl u_csc_clock_ctrl (.clock, .resetn, .addr, .wdata, .wr, .rd, .rdata, .chan_evt, .chan_pub,
    .irq_en_shared, .irq_en_set, .irq_en_clr, .fast_osc_on, .slow_osc_on, .slow_osc_src);

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string name);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(name, rdata, exp);
  endtask
  task automatic pulse(input logic [15:0] ch);
    @(posedge clock);
    chan_evt <= ch;
    @(posedge clock);
    chan_evt <= 16'h0000;
  endtask
  // Bounded wait for an oscillator to reach a level
  task automatic wait_osc(input logic fast, input logic lvl);
    for (int i = 0; i < 40; i++) begin
      @(posedge clock);
      #1;
      if ((fast ? fast_osc_on : slow_osc_on) === lvl) return;
    end
    miscompares++;
    $display("ERROR oscillator wait timed out");
    give_verdict();
  endtask

  initial begin
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    rd_chk(12'h414, 32'h0000_0000, "slow run");
    rd_chk(12'h41c, 32'h0000_0000, "slow copy");
    rd_chk(12'h7f0, 32'h0000_0000, "unmapped");
    wr_reg(12'h518, 32'h0000_0002);
    rd_chk(12'h518, 32'h0000_0002, "slow select");
    wr_reg(12'h008, 32'h0000_0000);
    rd_chk(12'h414, 32'h0000_0000, "slow run zero write");
    wr_reg(12'h008, 32'h0000_0001);
    rd_chk(12'h414, 32'h0000_0001, "slow run");
    rd_chk(12'h008, 32'h0000_0000, "task read");
    // A later select change must not disturb the copy
    wr_reg(12'h518, 32'h0000_0001);
    wait_osc(1'b0, 1'b1);
    chk("slow source", 32'(slow_osc_src), 32'h0000_0002);
    rd_chk(12'h418, 32'h0001_0002, "slow stat");
    rd_chk(12'h41c, 32'h0000_0002, "slow copy");
    wr_reg(12'h180, 32'h8000_0005);
    wr_reg(12'h000, 32'h0000_0001);
    rd_chk(12'h408, 32'h0000_0001, "fast run");
    rd_chk(12'h40c, 32'h0000_0001, "fast stat req");
    wait_osc(1'b1, 1'b1);
    rd_chk(12'h40c, 32'h0001_0001, "fast stat");
    rd_chk(12'h100, 32'h0000_0001, "fast started");
    chk("publish", 32'(pub_seen), 32'h0000_0020);
    wr_reg(12'h004, 32'h0000_0001);
    wait_osc(1'b1, 1'b0);
    rd_chk(12'h408, 32'h0000_0000, "fast run stop");
    wr_reg(12'h080, 32'h0000_0003);
    pulse(16'h0008);
    repeat (30) @(posedge clock);
    #1 chk("unsubscribed", 32'(fast_osc_on), 32'h0000_0000);
    wr_reg(12'h080, 32'h8000_0003);
    rd_chk(12'h080, 32'h8000_0003, "subscribe cfg");
    pulse(16'h0010);
    repeat (30) @(posedge clock);
    #1 chk("other channel", 32'(fast_osc_on), 32'h0000_0000);
    pulse(16'h0008);
    wait_osc(1'b1, 1'b1);
    rd_chk(12'h100, 32'h0000_0001, "fast started again");
    wr_reg(12'h100, 32'h0000_0000);
    rd_chk(12'h100, 32'h0000_0000, "fast started clear");
    wr_reg(12'h00c, 32'h0000_0001);
    wait_osc(1'b0, 1'b0);
    rd_chk(12'h414, 32'h0000_0000, "slow run stop");
    wr_reg(12'h304, 32'h0000_0003);
    #1 chk("irq set", 32'(irq_en_set), 32'h0000_0003);
    wr_reg(12'h308, 32'h0000_0002);
    #1 chk("irq clr", 32'(irq_en_clr), 32'h0000_0002);
    rd_chk(12'h300, 32'h0000_0002, "irq enable");
    // Whole-register write sets the ones and clears the zeros
    wr_reg(12'h300, 32'h0000_0001);
    irq_en_shared <= 2'h1;
    #1 chk("irq en set", 32'(irq_en_set), 32'h0000_0001);
    chk("irq en clr", 32'(irq_en_clr), 32'h0000_0002);
    rd_chk(12'h304, 32'h0000_0001, "irq enable set read");
    give_verdict();
  end
endmodule // tb_top
